//--- verilog/spcs_regs.svh
// spcs register map, field positions, reset values and timing counts.
// assumes a 32-bit avalon-mm slave with byte addresses, one word each.
`ifndef SPCS_REGS_SVH
`define SPCS_REGS_SVH

`define SPCS_CTRL_OFS 5'h00
`define SPCS_DIV_OFS  5'h04
`define SPCS_TXD_OFS  5'h08
`define SPCS_RXD_OFS  5'h0c
`define SPCS_STAT_OFS 5'h10

// control fields
`define SPCS_C_EN  0
`define SPCS_C_MST 1
`define SPCS_C_CSM 2
`define SPCS_C_TCP 4
`define SPCS_C_TSP 5
`define SPCS_C_RSP 6
`define SPCS_C_SCS 7

// status fields
`define SPCS_S_BUSY 0
`define SPCS_S_TXE  1
`define SPCS_S_TXF  2
`define SPCS_S_RXV  3
`define SPCS_S_OVR  4
`define SPCS_S_UDR  5
`define SPCS_S_TCD  8
`define SPCS_S_RCD  9
`define SPCS_S_TSD  10
`define SPCS_S_RSD  11
`define SPCS_S_SCS  12
`define SPCS_S_DIV  16

`define SPCS_CTRL_RST 32'h0000_0000
`define SPCS_DIV_RST  8'h01
// divide value forced in slave: sample clock at half the cpu clock
`define SPCS_SLV_DIV  8'h01
// smallest usable divide value: one core cycle per clock phase
`define SPCS_MIN_DIV  8'h01

`endif

//--- verilog/spcs_pkg.sv
// spcs shared types: link engine states.
// assumes spcs_regs.svh is included by the design files.
`default_nettype none
package spcs_pkg;
  typedef enum logic [1:0] {
    SPCS_IDLE  = 2'b00,
    SPCS_LEAD  = 2'b01,
    SPCS_SHIFT = 2'b10
  } spcs_state_e;
endpackage
`default_nettype wire

//--- verilog/spcs_fifo.sv
// spcs_fifo: flip-flop fifo with valid/ready on both sides.
// assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module spcs_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  // count is one bit wider than the pointers so full differs from empty
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } spcs_fifo_s;

  spcs_fifo_s q;
  spcs_fifo_s n;
  logic       do_push;
  logic       do_pop;

  assign in_ready  = (q.cnt != FULL);
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rp];
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;

  always_comb begin
    n = q;
    if (do_push) begin
      n.mem[q.wp] = in_data;
      n.wp = (q.wp == LAST) ? '0 : q.wp + 1'b1;
    end
    if (do_pop) begin
      n.rp = (q.rp == LAST) ? '0 : q.rp + 1'b1;
    end
    if (do_push && !do_pop) begin
      n.cnt = q.cnt + 1'b1;
    end else if (do_pop && !do_push) begin
      n.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule
`default_nettype wire

//--- verilog/spcs_top.sv
// spcs_top: clock-stop (spi style) serial port with avalon-mm registers.
// assumes pins synchronous to core_clk; rx sync pin tied to tx sync pin.
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "spcs_regs.svh"
module spcs_top import spcs_pkg::*; #(
  parameter int W     = 8,
  parameter int DIV_W = 8,
  parameter int DEPTH = 16
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        serial_transmit_clock_in,
  output logic             serial_transmit_clock_out,
  output logic             serial_transmit_clock_oe,
  input  wire logic        transmit_frame_sync_pin_in,
  output logic             transmit_frame_sync_pin_out,
  output logic             transmit_frame_sync_pin_oe,
  input  wire logic        receive_frame_sync_pin_in,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_out_oe
);
  localparam int CW = $clog2(2 * W + 1);
  localparam logic [CW-1:0]   TW    = CW'(2 * W);
  localparam logic [CW-2:0]   LASTB = (CW-1)'(W - 1);
  localparam logic [DIV_W:0]  ONE   = (DIV_W+1)'(1);

  typedef struct packed {
    logic              wait_r;
    logic [31:0]       rdata;
    logic              en;
    logic              mst;
    logic [1:0]        csm;
    logic              tcp;
    logic              tsp;
    logic              rsp;
    logic              scs;
    logic [DIV_W-1:0]  div;
    spcs_state_e       st;
    logic [DIV_W:0]    tm;
    logic [CW-1:0]     edg;
    logic              sck;
    logic              sck_oe;
    logic              fs_pin;
    logic              fs_oe;
    logic              dout;
    logic              dout_oe;
    logic [W-1:0]      tsh;
    logic [W-1:0]      rsh;
    logic [W-1:0]      rxd;
    logic              rxv;
    logic              ovr;
    logic              udr;
    logic              tick;
    logic              sck_d;
    logic              sfr_d;
    logic              tcd;
    logic              rcd;
    logic              tsd;
    logic              rsd;
    logic [DIV_W:0]    hl;
    logic [DIV_W:0]    hp;
  } spcs_top_s;

  spcs_top_s        q;
  spcs_top_s        n;
  logic             push_v;
  logic             pop_r;
  logic             f_in_ready;
  logic             f_out_valid;
  logic [W-1:0]     f_out_data;
  logic [DIV_W-1:0] eff_div;
  logic             eff_scs;
  logic [DIV_W:0]   per;
  logic [DIV_W:0]   lo_w;
  logic [DIV_W:0]   hi_w;
  logic [DIV_W:0]   idle_w;
  logic [DIV_W:0]   act_w;
  logic [DIV_W:0]   lead_w;
  logic             dly;
  logic             cs_on;
  logic             rxok;
  logic             sfr;

  spcs_fifo #(
    .W     (W),
    .DEPTH (DEPTH)
  ) u_txq (
    .clk       (core_clk),
    .rst       (sys_rst),
    .in_valid  (push_v),
    .in_ready  (f_in_ready),
    .in_data   (avs_writedata[W-1:0]),
    .out_valid (f_out_valid),
    .out_ready (pop_r),
    .out_data  (f_out_data)
  );

  // divide 0 would need a half-cycle phase, so it is lifted to 1
  assign eff_div = !q.mst ? `SPCS_SLV_DIV :
                   (q.div < `SPCS_MIN_DIV) ? `SPCS_MIN_DIV : q.div;
  assign eff_scs = q.scs | !q.mst;
  assign per     = {1'b0, eff_div} + ONE;
  assign lo_w    = per >> 1;
  assign hi_w    = per - lo_w;
  assign idle_w  = q.tcp ? hi_w : lo_w;
  assign act_w   = q.tcp ? lo_w : hi_w;
  assign dly     = (q.csm == 2'b11);
  assign lead_w  = dly ? per : idle_w;
  assign cs_on   = q.en && q.csm[1];
  assign rxok    = receive_frame_sync_pin_in ^ q.rsp;
  assign sfr     = transmit_frame_sync_pin_in ^ q.tsp;

  // one clock edge k of a frame: sample or drive by mode
  function automatic spcs_top_s do_edge(spcs_top_s s, logic [CW-1:0] k,
                                        logic d, logic ok, logic din);
    logic samp;
    samp = d ? !k[0] : k[0];
    if (samp && ok) begin
      s.rsh = {s.rsh[W-2:0], din};
      if (k[CW-1:1] == LASTB) begin
        s.rxd = s.rsh;
        s.ovr = s.ovr | s.rxv;
        s.rxv = 1'b1;
      end
    end else if (!samp) begin
      s.dout = s.tsh[W-1];
      s.tsh  = {s.tsh[W-2:0], 1'b0};
    end
    return s;
  endfunction

  // frame start; delayed mode puts the first bit out with the enable
  function automatic spcs_top_s do_load(spcs_top_s s, logic d,
                                        logic [W-1:0] w);
    s.tsh     = w;
    s.edg     = '0;
    s.dout_oe = 1'b1;
    if (d) begin
      s.dout = w[W-1];
      s.tsh  = {w[W-2:0], 1'b0};
    end
    return s;
  endfunction

  always_comb begin
    n      = q;
    push_v = 1'b0;
    pop_r  = 1'b0;
    n.wait_r = 1'b1;
    if (q.wait_r && (avs_read || avs_write)) begin
      n.wait_r = 1'b0;
      n.rdata  = '0;
      if (avs_write) begin
        if (avs_address == `SPCS_CTRL_OFS) begin
          // changing mode mid-frame truncates the frame
          n.en  = avs_writedata[`SPCS_C_EN];
          n.mst = avs_writedata[`SPCS_C_MST];
          n.csm = avs_writedata[`SPCS_C_CSM +: 2];
          n.tcp = avs_writedata[`SPCS_C_TCP];
          n.tsp = avs_writedata[`SPCS_C_TSP];
          n.rsp = avs_writedata[`SPCS_C_RSP];
          n.scs = avs_writedata[`SPCS_C_SCS];
        end else if (avs_address == `SPCS_DIV_OFS) begin
          n.div = avs_writedata[DIV_W-1:0];
        end else if (avs_address == `SPCS_TXD_OFS) begin
          push_v   = 1'b1;
          n.wait_r = !f_in_ready;
        end else if (avs_address == `SPCS_STAT_OFS) begin
          if (avs_writedata[`SPCS_S_OVR]) n.ovr = 1'b0;
          if (avs_writedata[`SPCS_S_UDR]) n.udr = 1'b0;
        end
      end else if (avs_address == `SPCS_CTRL_OFS) begin
        n.rdata[`SPCS_C_EN]       = q.en;
        n.rdata[`SPCS_C_MST]      = q.mst;
        n.rdata[`SPCS_C_CSM +: 2] = q.csm;
        n.rdata[`SPCS_C_TCP]      = q.tcp;
        n.rdata[`SPCS_C_TSP]      = q.tsp;
        n.rdata[`SPCS_C_RSP]      = q.rsp;
        n.rdata[`SPCS_C_SCS]      = q.scs;
      end else if (avs_address == `SPCS_DIV_OFS) begin
        n.rdata[DIV_W-1:0] = q.div;
      end else if (avs_address == `SPCS_RXD_OFS) begin
        n.rdata[W-1:0] = q.rxd;
        n.rxv = 1'b0;
      end else if (avs_address == `SPCS_STAT_OFS) begin
        n.rdata[`SPCS_S_BUSY] = (q.st != SPCS_IDLE);
        n.rdata[`SPCS_S_TXE]  = !f_out_valid;
        n.rdata[`SPCS_S_TXF]  = !f_in_ready;
        n.rdata[`SPCS_S_RXV]  = q.rxv;
        n.rdata[`SPCS_S_OVR]  = q.ovr;
        n.rdata[`SPCS_S_UDR]  = q.udr;
        n.rdata[`SPCS_S_TCD]  = q.tcd;
        n.rdata[`SPCS_S_RCD]  = q.rcd;
        n.rdata[`SPCS_S_TSD]  = q.tsd;
        n.rdata[`SPCS_S_RSD]  = q.rsd;
        n.rdata[`SPCS_S_SCS]  = eff_scs;
        n.rdata[`SPCS_S_DIV +: DIV_W] = eff_div;
      end
    end

    n.tcd    = q.mst;
    n.tsd    = q.mst;
    n.rcd    = 1'b0;
    n.rsd    = 1'b0;
    n.sck_oe = cs_on && q.tcd;
    n.fs_oe  = cs_on && q.tsd;
    // slave logic runs at half rate, matching its sample clock
    n.tick   = q.mst | !q.tick;

    // engine runs after the bus so a new event beats a clear
    if (!cs_on) begin
      n.st      = SPCS_IDLE;
      n.sck     = q.tcp;
      n.dout_oe = 1'b0;
      n.edg     = '0;
    end else if (q.mst) begin
      case (q.st)
        SPCS_IDLE: begin
          n.sck     = q.tcp;
          n.dout_oe = 1'b0;
          if (f_out_valid) begin
            pop_r = 1'b1;
            n     = do_load(n, dly, f_out_data);
            n.st  = SPCS_LEAD;
            n.tm  = lead_w - ONE;
          end
        end
        SPCS_LEAD, SPCS_SHIFT: begin
          if (q.tm != '0) begin
            n.tm = q.tm - ONE;
          end else if (q.edg == TW) begin
            n.st      = SPCS_IDLE;
            n.dout_oe = 1'b0;
          end else begin
            n     = do_edge(n, q.edg, dly, rxok, serial_data_in);
            n.sck = !q.sck;
            n.edg = q.edg + 1'b1;
            n.st  = SPCS_SHIFT;
            n.tm  = q.edg[0] ? idle_w - ONE : act_w - ONE;
          end
        end
        default: begin
          n.st = SPCS_IDLE;
        end
      endcase
    end else if (q.tick) begin
      n.sfr_d = sfr;
      n.sck_d = serial_transmit_clock_in;
      if (sfr && !q.sfr_d) begin
        n    = do_load(n, dly, f_out_valid ? f_out_data : '0);
        n.udr = q.udr | !f_out_valid;
        pop_r = f_out_valid;
        n.st  = SPCS_SHIFT;
      end else if (sfr) begin
        if (serial_transmit_clock_in != q.sck_d && q.edg != TW) begin
          n     = do_edge(n, q.edg, dly, rxok, serial_data_in);
          n.edg = q.edg + 1'b1;
        end
      end else begin
        n.st      = SPCS_IDLE;
        n.dout_oe = 1'b0;
      end
    end

    // internal frame is active high; polarity one makes the pin active low
    n.fs_pin = q.mst && (n.st != SPCS_IDLE) ? !n.tsp : n.tsp;
    n.hl = (n.sck != q.sck || q.st == SPCS_IDLE) ? ONE : q.hl + ONE;
    n.hp = (n.sck && !q.sck) ? ONE : q.hp + ONE;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q        <= '0;
      q.wait_r <= 1'b1;
      q.div    <= `SPCS_DIV_RST;
      q.tick   <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign avs_readdata                = q.rdata;
  assign avs_waitrequest             = q.wait_r;
  assign serial_transmit_clock_out   = q.sck;
  assign serial_transmit_clock_oe    = q.sck_oe;
  assign transmit_frame_sync_pin_out = q.fs_pin;
  assign transmit_frame_sync_pin_oe  = q.fs_oe;
  assign serial_data_out             = q.dout;
  assign serial_data_out_oe          = q.dout_oe;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic m_edge;
  assign m_edge = q.mst && cs_on && q.st != SPCS_IDLE && q.tm == '0 &&
                  q.edg != TW;

  property p_period;
    (m_edge && q.st == SPCS_SHIFT && !q.sck && q.edg >= CW'(2))
      |-> q.hp == per;
  endproperty
  a_period: assert property (p_period)
    else $error("clock period differs from divide value plus one");

  property p_low;
    (m_edge && q.st == SPCS_SHIFT && !q.sck) |-> q.hl == lo_w;
  endproperty
  a_low: assert property (p_low)
    else $error("clock low phase has wrong width");

  property p_high;
    (m_edge && q.st == SPCS_SHIFT && q.sck) |-> q.hl == hi_w;
  endproperty
  a_high: assert property (p_high)
    else $error("clock high phase has wrong width");

  property p_slv_tick;
    (!q.mst && q.tick) |=> q.mst || (!q.tick && eff_div == `SPCS_SLV_DIV);
  endproperty
  a_slv_tick: assert property (p_slv_tick)
    else $error("slave sample tick not at half rate");

  property p_enable_low;
    (q.mst && q.tsp && q.st == SPCS_LEAD) |=> !transmit_frame_sync_pin_out;
  endproperty
  a_enable_low: assert property (p_enable_low)
    else $error("slave enable not driven low during frame");

  property p_slv_invert;
    (!q.mst && q.tsp && transmit_frame_sync_pin_in [*3])
      |-> !serial_data_out_oe;
  endproperty
  a_slv_invert: assert property (p_slv_invert)
    else $error("slave drives data while enable pin is high");

  property p_dir_mst;
    (q.mst && cs_on) [*2] |=> serial_transmit_clock_oe && q.tcd && q.tsd
                             && !q.rcd && !q.rsd;
  endproperty
  a_dir_mst: assert property (p_dir_mst)
    else $error("master direction settings wrong");

  property p_dir_slv;
    (!q.mst) [*2] |=> !serial_transmit_clock_oe &&
                      !transmit_frame_sync_pin_oe && !q.tcd && !q.tsd;
  endproperty
  a_dir_slv: assert property (p_dir_slv)
    else $error("slave drives a clock or sync pin");

  property p_lead;
    (q.mst && cs_on && q.st == SPCS_LEAD && q.tm == '0) |-> q.hl == lead_w;
  endproperty
  a_lead: assert property (p_lead)
    else $error("enable lead before first edge has wrong length");

  property p_sample;
    (m_edge && (dly ? !q.edg[0] : q.edg[0]) && rxok)
      |=> q.rsh[0] == $past(serial_data_in);
  endproperty
  a_sample: assert property (p_sample)
    else $error("data not sampled on the sampling edge");

  property p_drive;
    (q.mst && q.st == SPCS_SHIFT && $changed(serial_data_out))
      |-> $past(m_edge) && ($past(dly) == $past(q.edg[0]));
  endproperty
  a_drive: assert property (p_drive)
    else $error("data changed away from the driving edge");

  c_mst_frame: cover property (q.mst && q.st == SPCS_SHIFT && q.edg == TW
                               ##1 q.st == SPCS_SHIFT);
  c_slv_frame: cover property (!q.mst && q.rxv && q.st == SPCS_SHIFT);
  c_fifo_full: cover property (!f_in_ready && avs_write && q.wait_r);
  c_overrun:   cover property ($rose(q.ovr));
endmodule
`default_nettype wire

//--- sim/spcs_spi_peer.sv
// spcs_spi_peer: behavioural spi slave facing the port in master mode.
// assumes the bench resolves every pin to its wire level first.
`timescale 1ns/1ps
`default_nettype none
module spcs_spi_peer (
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  input  wire logic       dly,
  input  wire logic       cpol,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      got,
  output int              nbits
);
  logic [7:0] sh;
  logic       q;
  logic       lead;
  initial begin
    sh = 8'h00;
    q = 1'b0;
    got = 8'h00;
    nbits = 0;
  end
  // released line shows the inverse so a stale bit never passes for data
  assign miso = cs_n ? ~q : q;
  always @(negedge cs_n) begin
    sh = tx;
    q = tx[7];
    nbits = 0;
  end
  always @(sck) begin
    if (!cs_n) begin
      lead = (sck != cpol);
      if (lead == dly) begin
        got = {got[6:0], mosi};
        nbits++;
      end else if (nbits > 0) begin
        sh = sh << 1;
        q = sh[7];
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/tb_spcs_top.sv
// tb_spcs_top: table of master frames, fifo fill, slave frame, reset.
// assumes the spcs design files and spcs_spi_peer compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "spcs_regs.svh"
module tb_spcs_top;
  typedef struct {
    logic [7:0] dv;
    logic [1:0] csm;
    logic       tcp;
    logic [7:0] tx;
    logic [7:0] rx;
  } spcs_row_s;
  spcs_row_s   rows [4];
  logic        core_clk = 1'b0, sys_rst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic        avs_waitrequest, sck_o, sck_oe, fs_o, fs_oe, dout, dout_oe;
  logic        bsck = 1'b0, bfs = 1'b1, bdin = 1'b0, slv = 1'b0;
  logic        mdly = 1'b1, mcpol = 1'b0, pmiso, fs_q = 1'b1, sck_q;
  logic        idle_ok;
  logic [7:0]  ptx = 8'h00, pgot, cap;
  wire         sck_w = sck_oe ? sck_o : bsck;
  wire         fs_w = fs_oe ? fs_o : bfs;
  wire         sdo_w = dout_oe ? dout : ~dout;
  wire         sdi_w = slv ? bdin : pmiso;
  int          n_errors = 0, num_checks = 0, pbits, exp_lo, exp_hi, nfr = 0;
  int          cyc = 0, t_fs = 0, t_last = 0, edges = 0, lead = 0, werr = 0;
  int          base;
  always #12.5 core_clk = ~core_clk;
  spcs_top spcs_top_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .serial_transmit_clock_in(sck_w),
    .serial_transmit_clock_out(sck_o), .serial_transmit_clock_oe(sck_oe),
    .transmit_frame_sync_pin_in(fs_w), .transmit_frame_sync_pin_out(fs_o),
    .transmit_frame_sync_pin_oe(fs_oe), .receive_frame_sync_pin_in(fs_w),
    .serial_data_in(sdi_w), .serial_data_out(dout),
    .serial_data_out_oe(dout_oe));
  spcs_spi_peer spcs_spi_peer_inst (
    .sck(sck_w), .cs_n(fs_w), .mosi(sdo_w), .dly(mdly), .cpol(mcpol),
    .tx(ptx), .miso(pmiso), .got(pgot), .nbits(pbits));
  // link monitor: lead from enable to first edge, phase widths, frames
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (fs_q && !fs_w) begin
      t_fs = cyc;
      edges = 0;
      idle_ok = (sck_w === mcpol);
    end
    if (!fs_w && sck_w !== sck_q) begin
      if (edges == 0) lead = cyc - t_fs;
      else if ((sck_q ? exp_hi : exp_lo) != cyc - t_last) werr++;
      edges++;
      t_last = cyc;
    end
    if (!fs_q && fs_w) nfr++;
    fs_q = fs_w;
    sck_q = sck_w;
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic we, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 300);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 300) begin
      chk("bus timeout", 1, 0);
      tally_and_finish();
    end
  endtask
  task automatic wait_fr(input int n);
    int k;
    k = 0;
    while (nfr < n && k < 3000) begin
      @(posedge core_clk);
      k++;
    end
    if (nfr < n) begin
      chk("frame timeout", 1, 0);
      tally_and_finish();
    end
  endtask
  initial begin
    rows[0] = '{8'h01, 2'b11, 1'b0, 8'ha5, 8'h3c};
    rows[1] = '{8'h02, 2'b10, 1'b1, 8'h96, 8'hc3};
    rows[2] = '{8'h04, 2'b11, 1'b1, 8'h5a, 8'h81};
    rows[3] = '{8'h03, 2'b10, 1'b0, 8'h0f, 8'hf0};
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    bus(0, `SPCS_CTRL_OFS, 0, q); chk("ctrl rst", q, 32'h0);
    bus(0, `SPCS_DIV_OFS, 0, q); chk("div rst", q, 32'h1);
    bus(1, 5'h14, 32'hffff_ffff, q);
    bus(0, 5'h14, 0, q); chk("unmapped", q, 32'h0);
    bus(0, `SPCS_STAT_OFS, 0, q); chk("stat rst", q, 32'h0001_1002);
    $display("register reset test done");
    for (int i = 0; i < 4; i++) begin
      exp_lo = rows[i].dv[0] ? (rows[i].dv + 1) / 2 : rows[i].dv / 2;
      exp_hi = rows[i].dv[0] ? (rows[i].dv + 1) / 2 : rows[i].dv / 2 + 1;
      mdly = rows[i].csm[0];
      mcpol = rows[i].tcp;
      ptx = rows[i].rx;
      werr = 0;
      base = nfr;
      bus(1, `SPCS_DIV_OFS, {24'h0, rows[i].dv}, q);
      bus(1, `SPCS_CTRL_OFS, {24'h0, 3'b111, rows[i].tcp, rows[i].csm,
          2'b11}, q);
      bus(0, `SPCS_STAT_OFS, 0, q); chk("dirs", q[11:8], 4'h5);
      chk("fs idle", fs_w, 1'b1);
      bus(1, `SPCS_TXD_OFS, {24'h0, rows[i].tx}, q);
      wait_fr(base + 1);
      chk("lead", lead, mdly ? rows[i].dv + 1 :
          (mcpol ? exp_hi : exp_lo));
      chk("idle lvl", idle_ok, 1'b1);
      chk("edges", edges, 16);
      chk("widths", werr, 0);
      chk("peer got", pgot, rows[i].tx);
      chk("peer bits", pbits, 8);
      chk("data oe", dout_oe, 1'b0);
      bus(0, `SPCS_RXD_OFS, 0, q); chk("rxd", q, {24'h0, rows[i].rx});
      $display("row %0d done", i);
    end
    bus(1, `SPCS_CTRL_OFS, 32'h0, q);
    for (int i = 0; i < 16; i++) bus(1, `SPCS_TXD_OFS, 32'h10 + i, q);
    bus(0, `SPCS_STAT_OFS, 0, q); chk("fifo full", q[2:1], 2'b10);
    exp_lo = 1;
    exp_hi = 1;
    mdly = 1'b1;
    mcpol = 1'b0;
    base = nfr;
    bus(1, `SPCS_DIV_OFS, 32'h1, q);
    bus(1, `SPCS_CTRL_OFS, 32'h0000_00ef, q);
    wait_fr(base + 16);
    chk("last word", pgot, 8'h1f);
    bus(0, `SPCS_STAT_OFS, 0, q); chk("drained", q[2:0], 3'b010);
    chk("rx flags", q[4:3], 2'b11);
    bus(1, `SPCS_STAT_OFS, 32'h10, q);
    bus(0, `SPCS_STAT_OFS, 0, q); chk("ovr clear", q[4], 1'b0);
    $display("fifo test done");
    bus(1, `SPCS_RXD_OFS, 0, q);
    bus(1, `SPCS_DIV_OFS, 32'h5, q);
    bus(1, `SPCS_CTRL_OFS, 32'h0000_006d, q);
    bus(0, `SPCS_STAT_OFS, 0, q); chk("slv stat", q[23:8], 16'h0110);
    bus(0, `SPCS_RXD_OFS, 0, q);
    bus(1, `SPCS_TXD_OFS, 32'h6b, q);
    slv <= 1'b1;
    bfs <= 1'b0;
    for (int b = 7; b >= 0; b--) begin
      bdin <= 1'(8'hd2 >> b);
      repeat (6) @(posedge core_clk);
      bsck <= 1'b1;
      cap = {cap[6:0], sdo_w};
      repeat (6) @(posedge core_clk);
      bsck <= 1'b0;
    end
    repeat (6) @(posedge core_clk);
    bfs <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("slv tx", cap, 8'h6b);
    bus(0, `SPCS_RXD_OFS, 0, q); chk("slv rx", q, 32'hd2);
    $display("slave test done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    bus(0, `SPCS_CTRL_OFS, 0, q); chk("ctrl rst2", q, 32'h0);
    bus(0, `SPCS_DIV_OFS, 0, q); chk("div rst2", q, 32'h1);
    $display("reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
